// file: core/sar_conversion_sequencer.sv
// successive-approximation conversion sequencer with switch control
`timescale 1ns/100ps

// Contract
// - each result bit takes one approximation period, eight periods after acquisition.
// - conversion starts with only the top bit of the approximation register set.
// - a trial bit stays 1 when the comparator is high and is cleared otherwise.
// - a decided bit keeps its value and the next lower bit is set for trial.
// - the result register takes approximation bits 7 to 1 and the comparator level at the last decision and holds the finished result the bus master reads.
// - every conversion is an acquisition phase followed by a conversion phase.
// - acquisition grounds top plates and puts the input on bottom plates, then opens both.
// - phase one grounds all bottom plates and phase two switches trial capacitors.
// - in phase two each capacitor whose bit is set selects reference, the rest ground.
// - an eight-way channel multiplexer picks the input and results are eight bits.
// - with no conversion and no addressing, the internal clock is off, and the core is off in power modes 00 and 10.
// - command bit 7 selects single-ended when 1 and differential when 0.
// - command bits 6 to 4 select the multiplexer channel.
// - command bits 3 to 2 choose the power and reference mode.
module sar_conversion_sequencer
    import sar_seq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic start_conv,
    input wire logic cmd_valid,
    input wire logic [CMD_W-1:0] cmd_byte,
    input wire logic addressed,
    input wire logic comp_out,
    output logic [RESULT_W-1:0] result,
    output logic result_valid,
    output logic busy,
    output logic conv_done,
    output logic [CHAN_W-1:0] channel_sel,
    output logic single_ended_sel,
    output logic [1:0] power_mode_sel,
    output logic top_plate_gnd,
    output logic bottom_plate_in,
    output logic [RESULT_W-1:0] cap_sel_ref,
    output logic bottom_plate_gnd,
    output logic core_power_en,
    output logic core_clk_en,
    output logic ref_power_en
);
    seq_state_type state_r;
    logic [RESULT_W-1:0] sar_r;
    logic [BIT_IDX_W-1:0] bit_idx_r;
    logic [CNT_W-1:0] acq_cnt_r;
    logic [2:0] comp_sync_r;
    logic comp_level_r;
    logic period_start;
    logic phase_one;
    logic phase_two;
    logic decide;
    logic period_busy;
    logic conv_active;

    // comparator is asynchronous to sys_clk; accept a change once stages agree
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            comp_sync_r <= 3'h0;
            comp_level_r <= 1'b0;
        end
        else
        begin
            comp_sync_r <= {comp_sync_r[1:0], comp_out};
            if (comp_sync_r[1] == comp_sync_r[2])
                comp_level_r <= comp_sync_r[2];
        end
    end

    // command fields; a command during a conversion is dropped, not held
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            single_ended_sel <= 1'b0;
            channel_sel <= CHAN_RST;
            power_mode_sel <= PWR_RST;
        end
        else if (cmd_valid && !conv_active)
        begin
            single_ended_sel <= cmd_byte[CMD_SINGLE_BIT];
            channel_sel <= cmd_byte[CMD_CHAN_HI:CMD_CHAN_LO];
            power_mode_sel <= cmd_byte[CMD_PWR_HI:CMD_PWR_LO];
        end
    end

    assign conv_active = (state_r == ST_ACQ) || (state_r == ST_CONV);
    assign period_start = (state_r == ST_CONV) && !period_busy;

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r <= ST_IDLE;
            acq_cnt_r <= '0;
            bit_idx_r <= MSB_IDX;
        end
        else
        begin
            unique case (state_r)
                ST_IDLE, ST_DONE:
                begin
                    acq_cnt_r <= '0;
                    if (start_conv)
                        state_r <= ST_ACQ;
                end
                ST_ACQ:
                    if (acq_cnt_r == CNT_W'(ACQ_CYCLES - 1))
                    begin
                        state_r <= ST_CONV;
                        bit_idx_r <= MSB_IDX;
                    end
                    else
                        acq_cnt_r <= acq_cnt_r + 1'b1;
                ST_CONV:
                    if (decide)
                    begin
                        if (bit_idx_r == LSB_IDX)
                            state_r <= ST_DONE;
                        else
                            bit_idx_r <= bit_idx_r - 1'b1;
                    end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // approximation register
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            sar_r <= RESULT_RST;
        else if (state_r == ST_ACQ && acq_cnt_r == CNT_W'(ACQ_CYCLES - 1))
            sar_r <= {1'b1, {(RESULT_W-1){1'b0}}};
        else if (state_r == ST_CONV && decide)
        begin
            sar_r[bit_idx_r] <= comp_level_r;
            if (bit_idx_r != LSB_IDX)
                sar_r[bit_idx_r - 1'b1] <= 1'b1;
        end
    end

    // result register only changes when a conversion finishes
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            result <= RESULT_RST;
            result_valid <= 1'b0;
        end
        else if (state_r == ST_CONV && decide && bit_idx_r == LSB_IDX)
        begin
            result <= {sar_r[RESULT_W-1:1], comp_level_r};
            result_valid <= 1'b1;
        end
        else if (start_conv && !conv_active)
            result_valid <= 1'b0;
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            conv_done <= 1'b0;
        else
            conv_done <= (state_r == ST_CONV) && decide && (bit_idx_r == LSB_IDX);
    end

    two_phase_gen u_phase (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .period_start(period_start),
        .phase_one(phase_one),
        .phase_two(phase_two),
        .decide(decide),
        .period_busy(period_busy)
    );

    // switch drive; between acquisition and phase one all switches stay open
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            top_plate_gnd <= 1'b0;
            bottom_plate_in <= 1'b0;
            bottom_plate_gnd <= 1'b0;
            cap_sel_ref <= '0;
        end
        else
        begin
            top_plate_gnd <= (state_r == ST_ACQ)
                && (acq_cnt_r != CNT_W'(ACQ_CYCLES - 1));
            bottom_plate_in <= (state_r == ST_ACQ)
                && (acq_cnt_r != CNT_W'(ACQ_CYCLES - 1));
            bottom_plate_gnd <= phase_one;
            cap_sel_ref <= phase_two ? sar_r : '0;
        end
    end

    // power gating; mode 00 powers down between conversions
    assign busy = conv_active;
    assign core_power_en = conv_active || addressed
        || (power_mode_sel == PWR_REF_OFF_ADC_ON)
        || (power_mode_sel == PWR_BOTH_ON);
    assign core_clk_en = conv_active || addressed;
    assign ref_power_en = (power_mode_sel == PWR_REF_ON_ADC_OFF)
        || (power_mode_sel == PWR_BOTH_ON);
endmodule // sar_conversion_sequencer

// file: core/sar_seq_pkg.sv
// constants shared by the conversion sequencer and its phase generator
package sar_seq_pkg;
    localparam int RESULT_W = 8;
    localparam int CHAN_W = 3;
    localparam int NUM_CHAN = 8;
    localparam int CMD_W = 8;
    localparam int CMD_SINGLE_BIT = 7;
    localparam int CMD_CHAN_HI = 6;
    localparam int CMD_CHAN_LO = 4;
    localparam int CMD_PWR_HI = 3;
    localparam int CMD_PWR_LO = 2;
    localparam logic [1:0] PWR_DOWN_BETWEEN = 2'h0;
    localparam logic [1:0] PWR_REF_OFF_ADC_ON = 2'h1;
    localparam logic [1:0] PWR_REF_ON_ADC_OFF = 2'h2;
    localparam logic [1:0] PWR_BOTH_ON = 2'h3;
    // phase timing; clock period and acquisition time in ns, counts in sys_clk cycles
    localparam int CLK_PERIOD_NS = 40;
    localparam int ACQ_TIME_NS = 400;
    localparam int ACQ_CYCLES = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PH_CYCLES = 2;
    localparam int DEAD_CYCLES = 1;
    localparam int CNT_W = 8;
    localparam int BIT_IDX_W = 3;
    localparam logic [BIT_IDX_W-1:0] MSB_IDX = 3'h7;
    localparam logic [BIT_IDX_W-1:0] LSB_IDX = 3'h0;
    localparam logic [RESULT_W-1:0] RESULT_RST = 8'h00;
    localparam logic [CHAN_W-1:0] CHAN_RST = 3'h0;
    localparam logic [1:0] PWR_RST = 2'h0;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ACQ = 3'b001,
        ST_CONV = 3'b011,
        ST_DONE = 3'b010
    } seq_state_type;
    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_ONE = 3'b001,
        PH_DEAD1 = 3'b011,
        PH_TWO = 3'b010,
        PH_DEAD2 = 3'b110
    } phase_state_type;
endpackage

// file: core/two_phase_gen.sv
// non-overlapping two-phase generator for one approximation period
`timescale 1ns/100ps
module two_phase_gen
    import sar_seq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic period_start,
    output logic phase_one,
    output logic phase_two,
    output logic decide,
    output logic period_busy
);
    phase_state_type state_r;
    logic [CNT_W-1:0] cnt_r;

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r <= PH_IDLE;
            cnt_r <= '0;
        end
        else
        begin
            unique case (state_r)
                PH_IDLE:
                begin
                    cnt_r <= '0;
                    if (period_start)
                        state_r <= PH_ONE;
                end
                PH_ONE:
                    if (cnt_r == CNT_W'(PH_CYCLES - 1))
                    begin
                        cnt_r <= '0;
                        state_r <= PH_DEAD1;
                    end
                    else
                        cnt_r <= cnt_r + 1'b1;
                PH_DEAD1:
                    if (cnt_r == CNT_W'(DEAD_CYCLES - 1))
                    begin
                        cnt_r <= '0;
                        state_r <= PH_TWO;
                    end
                    else
                        cnt_r <= cnt_r + 1'b1;
                PH_TWO:
                    if (cnt_r == CNT_W'(PH_CYCLES - 1))
                    begin
                        cnt_r <= '0;
                        state_r <= PH_DEAD2;
                    end
                    else
                        cnt_r <= cnt_r + 1'b1;
                PH_DEAD2:
                    if (cnt_r == CNT_W'(DEAD_CYCLES - 1))
                    begin
                        cnt_r <= '0;
                        state_r <= PH_IDLE;
                    end
                    else
                        cnt_r <= cnt_r + 1'b1;
                default:
                    state_r <= PH_IDLE;
            endcase
        end
    end

    // phases decoded from one state, so they can never be high together
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            phase_one <= 1'b0;
            phase_two <= 1'b0;
        end
        else
        begin
            phase_one <= (state_r == PH_IDLE && period_start)
                || (state_r == PH_ONE && cnt_r != CNT_W'(PH_CYCLES - 1));
            phase_two <= (state_r == PH_DEAD1 && cnt_r == CNT_W'(DEAD_CYCLES - 1))
                || (state_r == PH_TWO && cnt_r != CNT_W'(PH_CYCLES - 1));
        end
    end

    // comparator sampled at the close of phase two
    assign decide = (state_r == PH_TWO) && (cnt_r == CNT_W'(PH_CYCLES - 1));
    assign period_busy = (state_r != PH_IDLE);
endmodule // two_phase_gen

// file: verification/bus_master_model.sv
// behavioural bus master: configures, starts and reads the sequencer
`timescale 1ns/100ps
module bus_master_model
    import sar_seq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic [RESULT_W-1:0] result,
    output logic start_conv,
    output logic cmd_valid,
    output logic [CMD_W-1:0] cmd_byte,
    output logic addressed
);
    initial
    begin
        start_conv = 1'b0;
        cmd_valid = 1'b0;
        cmd_byte = 8'h00;
        addressed = 1'b0;
    end
    // all tasks are entered at a falling edge
    task automatic send_cmd(input logic [CMD_W-1:0] c);
        addressed = 1'b1;
        cmd_byte = c;
        cmd_valid = 1'b1;
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        // released byte inverted so a stale value cannot pass
        cmd_byte = ~c;
        addressed = 1'b0;
        // one idle cycle so a following call never re-raises a strobe in the same step
        @(negedge sys_clk);
    endtask
    task automatic start_once();
        start_conv = 1'b1;
        @(negedge sys_clk);
        start_conv = 1'b0;
    endtask
    task automatic read_result(output logic [RESULT_W-1:0] r);
        addressed = 1'b1;
        @(negedge sys_clk);
        r = result;
        addressed = 1'b0;
    endtask
    task automatic select(input logic v);
        addressed = v;
    endtask
endmodule // bus_master_model

// file: verification/sar_conversion_sequencer_tb.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/100ps
module sar_conversion_sequencer_tb
    import sar_seq_pkg::*;
;
    logic sys_clk, rst_b, start_conv, cmd_valid, addressed, comp_out, comp_nxt;
    logic result_valid, busy, conv_done, single_ended_sel, top_plate_gnd, bottom_plate_in;
    logic bottom_plate_gnd, core_power_en, core_clk_en, ref_power_en, bpg_q, cap_q, tpg_q;
    logic [7:0] cmd_byte, result, cap_sel_ref, vin, r;
    logic [2:0] channel_sel;
    logic [1:0] power_mode_sel;
    int checks = 0;
    int miscompares = 0;
    int nb = 7;
    int per = 0;
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    sar_conversion_sequencer dut_u (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .start_conv(start_conv),
        .cmd_valid(cmd_valid),
        .cmd_byte(cmd_byte),
        .addressed(addressed),
        .comp_out(comp_out),
        .result(result),
        .result_valid(result_valid),
        .busy(busy),
        .conv_done(conv_done),
        .channel_sel(channel_sel),
        .single_ended_sel(single_ended_sel),
        .power_mode_sel(power_mode_sel),
        .top_plate_gnd(top_plate_gnd),
        .bottom_plate_in(bottom_plate_in),
        .cap_sel_ref(cap_sel_ref),
        .bottom_plate_gnd(bottom_plate_gnd),
        .core_power_en(core_power_en),
        .core_clk_en(core_clk_en),
        .ref_power_en(ref_power_en)
    );
    bus_master_model mst_u (
        .sys_clk(sys_clk),
        .result(result),
        .start_conv(start_conv),
        .cmd_valid(cmd_valid),
        .cmd_byte(cmd_byte),
        .addressed(addressed)
    );
    // ideal comparator: with exact trials each decision equals the input bit
    always @(posedge sys_clk)
    begin
        bpg_q <= bottom_plate_gnd;
        cap_q <= |cap_sel_ref;
        tpg_q <= top_plate_gnd;
        if (top_plate_gnd === 1'b1)
        begin
            nb = 7;
            per = 0;
        end
        // next bit shown as sampling or the last trial ends, ahead of the synchroniser delay
        if (nb >= 0 && ((top_plate_gnd !== 1'b1 && tpg_q === 1'b1)
            || ((|cap_sel_ref) !== 1'b1 && cap_q === 1'b1)))
            comp_nxt <= vin[nb];
        if (bottom_plate_gnd === 1'b1 && bpg_q !== 1'b1)
            per = per + 1;
        if ((|cap_sel_ref) === 1'b1 && cap_q !== 1'b1)
        begin
            check("trial", cap_sel_ref, (vin & (8'hff << (nb + 1))) | (8'h01 << nb));
            nb = nb - 1;
        end
    end
    always @(negedge sys_clk) comp_out <= comp_nxt;
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        while (conv_done !== 1'b1 && n < 200)
        begin
            @(negedge sys_clk);
            n++;
        end
        check("done", {7'h0, conv_done, busy}, 8'h02);
    endtask
    task automatic t_cmd();
        logic [7:0] c;
        for (int i = 0; i < 16; i++)
        begin
            c = {i[3:0], i[1:0], 2'b11};
            mst_u.send_cmd(c);
            check("chan", {5'h0, channel_sel}, {5'h0, c[6:4]});
            check("sd", {7'h0, single_ended_sel}, {7'h0, c[7]});
            check("pwr", {ref_power_en, core_power_en, power_mode_sel}, {c[3:2], c[3:2]});
            check("clk", {7'h0, core_clk_en}, 8'h00);
        end
        mst_u.select(1'b1);
        @(negedge sys_clk);
        check("clk addr", {7'h0, core_clk_en}, 8'h01);
        mst_u.select(1'b0);
        $display("test commands done");
    endtask
    task automatic run_conv(input logic [7:0] v);
        vin = v;
        mst_u.start_once();
        wait_done();
        check("result", result, v);
        check("periods", 8'(per), 8'h08);
        @(negedge sys_clk);
        check("pulse", {conv_done, result_valid, 6'h0}, 8'h40);
        mst_u.read_result(r);
        check("read", r, v);
    endtask
    task automatic t_codes();
        logic [7:0] codes [6] = '{8'h00, 8'hff, 8'ha5, 8'h5a, 8'h80, 8'h7f};
        foreach (codes[i]) run_conv(codes[i]);
        $display("test codes done");
    endtask
    task automatic t_chain();
        logic [7:0] f;
        vin = 8'h3c;
        mst_u.start_once();
        wait_done();
        f = {single_ended_sel, channel_sel, power_mode_sel, 2'b00};
        vin = 8'hc3;
        mst_u.start_once();
        check("restart", {7'h0, busy}, 8'h01);
        mst_u.send_cmd(~f);
        mst_u.start_once();
        check("held", result, 8'h3c);
        wait_done();
        check("result2", result, 8'hc3);
        check("fields", {single_ended_sel, channel_sel, power_mode_sel, 2'b00}, f);
        $display("test chain done");
    endtask
    task automatic end_of_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
        begin
            $display("ALL TESTS PASSED");
        end
        else
        begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial
    begin
        rst_b = 1'b0;
        comp_nxt = 1'b0;
        comp_out = 1'b0;
        vin = 8'h00;
        repeat (5) @(negedge sys_clk);
        rst_b = 1'b1;
        check("reset", result, 8'h00);
        check("reset flags", {4'h0, result_valid, busy, conv_done, core_clk_en}, 8'h00);
        t_cmd();
        t_codes();
        t_chain();
        end_of_test();
    end
    initial
    begin
        #800000;
        miscompares++;
        end_of_test();
    end
endmodule // sar_conversion_sequencer_tb

// file: verification/sar_seq_sva.sv
// port assertions for the conversion sequencer
`timescale 1ns/100ps
module sar_seq_sva
    import sar_seq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic start_conv,
    input wire logic addressed,
    input wire logic [RESULT_W-1:0] result,
    input wire logic busy,
    input wire logic conv_done,
    input wire logic [CHAN_W-1:0] channel_sel,
    input wire logic single_ended_sel,
    input wire logic [1:0] power_mode_sel,
    input wire logic top_plate_gnd,
    input wire logic bottom_plate_in,
    input wire logic [RESULT_W-1:0] cap_sel_ref,
    input wire logic bottom_plate_gnd,
    input wire logic core_power_en,
    input wire logic core_clk_en,
    input wire logic ref_power_en
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    a_start_acq: assert property (start_conv && !busy |=> busy ##1 top_plate_gnd)
        else $error("start did not open acquisition");
    a_acq_length: assert property ($rose(top_plate_gnd) |-> top_plate_gnd[*8] ##1 top_plate_gnd
        ##1 !top_plate_gnd)
        else $error("acquisition switches held wrong length");
    a_plates_pair: assert property (top_plate_gnd || bottom_plate_in |-> top_plate_gnd
        && bottom_plate_in && !bottom_plate_gnd && cap_sel_ref == 8'h00)
        else $error("acquisition switches out of step");
    a_phase_timing: assert property ($rose(bottom_plate_gnd) |-> bottom_plate_gnd[*2]
        ##1 (!bottom_plate_gnd && cap_sel_ref == 8'h00) ##1 (cap_sel_ref != 8'h00)[*2]
        ##1 cap_sel_ref == 8'h00)
        else $error("phase sequence wrong");
    a_phase_apart: assert property (bottom_plate_gnd |-> cap_sel_ref == 8'h00)
        else $error("phases overlap");
    a_trial_busy: assert property (cap_sel_ref != 8'h00 |-> busy || conv_done)
        else $error("trial switches outside conversion");
    a_result_hold: assert property ($changed(result) |-> conv_done)
        else $error("result changed without completion");
    a_done_pulse: assert property (conv_done |-> !busy ##1 !conv_done)
        else $error("completion flag malformed");
    a_cmd_refused: assert property (busy |=> $stable({single_ended_sel, channel_sel,
        power_mode_sel}))
        else $error("command taken while busy");
    a_idle_clock: assert property (!busy && !addressed |-> !core_clk_en)
        else $error("core clock on while idle");
    a_busy_power: assert property (busy |-> core_clk_en && core_power_en)
        else $error("core off during conversion");
    a_ref_mode: assert property (ref_power_en == power_mode_sel[1])
        else $error("reference enable mismatch");
    c_done: cover property (conv_done);
    c_start_busy: cover property (start_conv && busy);
    c_addressed: cover property (addressed && !busy);
endmodule // sar_seq_sva

bind sar_conversion_sequencer sar_seq_sva chk_u (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .start_conv(start_conv),
    .addressed(addressed),
    .result(result),
    .busy(busy),
    .conv_done(conv_done),
    .channel_sel(channel_sel),
    .single_ended_sel(single_ended_sel),
    .power_mode_sel(power_mode_sel),
    .top_plate_gnd(top_plate_gnd),
    .bottom_plate_in(bottom_plate_in),
    .cap_sel_ref(cap_sel_ref),
    .bottom_plate_gnd(bottom_plate_gnd),
    .core_power_en(core_power_en),
    .core_clk_en(core_clk_en),
    .ref_power_en(ref_power_en)
);
